// ### rtl/enc_bus_pkg.sv
// Overview of operation
// - Cassette preset input uses preset one until a service selects preset two.
// - The serial bus carries up to 31 encoder nodes.
// - The serial bus always runs at 312.5 kbit/s, 160 clocks per bit for a nominal 307.2 kbit/s.
// - Asynchronous characters with parity; request and reply strictly alternate.
// - Character frame: start bit, eight data bits, parity bit, stop bit.
// - Requests go out on the address pair, replies come back on the data pair.
// - Node addresses 0 to 31; address 0 is global.
// - Every received position passes a plausibility check before it is valid.
// - One to four axes are mapped to the fieldbus.
// - Cam mode puts a 30-path cam pattern in the same slot format.
// - Each axis slot is four or two bytes, updated as one consistent unit.
// - Total input byte count follows the programmed number of axes.
// - Each slot carries an error flag for its value.
// - Encoder output data is optional, only for programming parameters or presets.
// - A service starts when its trigger bit rises while no other service is running.
// - Services never pause cyclic position acquisition.
// - Requested error status is returned in the diagnostic frame.
// - Short diagnostic mode reads one error per service, long mode reads four.
// - The error flag is the most significant bit of the slot.
// - Error flag rises when consecutive measuring errors exceed five.
// - Each axis buffers eight errors and reports the newest first.
// - Service axis 0 selects the cassette, 1 to 4 the encoders.
package enc_bus_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int BAUD_BPS = 307200;
	localparam int OVERSAMPLE = 8;
	localparam int TICK_CYCLES = CLK_HZ / (BAUD_BPS * OVERSAMPLE);
	localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);
	localparam logic [2:0] SAMPLE_PHASE = 3'h3;
	localparam logic [2:0] SHIFT_PHASE = 3'h7;
	localparam logic [3:0] STOP_INDEX = 4'hA;
	localparam int REPLY_TIMEOUT_US = 200;
	localparam int REPLY_TIMEOUT_CYCLES = REPLY_TIMEOUT_US * (CLK_HZ / 1000000);
	localparam int MAX_AXES = 4;
	localparam int MAX_NODES = 31;
	localparam logic [2:0] ERR_TOLERANCE = 3'h5;
	localparam int ERR_DEPTH = 8;
	localparam int FIFO_DEPTH = 4;
	localparam logic [2:0] REPLY_LAST = 3'h4;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [29:0] MAX_STEP = 30'h0010_0000;
	localparam logic [3:0] STATUS_BYTES = 4'h2;
	localparam int ERR_BIT = 31;
	localparam int SHORT_ERR_BIT = 15;
	localparam int POS_BITS = 30;
	localparam int SVC_POLL_BIT = 0;
	localparam int SVC_PRESET2_BIT = 1;
	localparam int SVC_ACTIVATE_BIT = 6;
	localparam logic [2:0] DIAG_SHORT_LAST = 3'h0;
	localparam logic [2:0] DIAG_LONG_LAST = 3'h3;
	localparam logic [2:0] CASSETTE_AXIS = 3'h0;
	localparam logic [2:0] ERR_NONE = 3'h0;
	localparam logic [2:0] ERR_TIMEOUT = 3'h1;
	localparam logic [2:0] ERR_PARITY = 3'h2;
	localparam logic [2:0] ERR_CRC = 3'h3;
	localparam logic [2:0] ERR_PLAUS = 3'h4;
	localparam logic [2:0] ERR_OVERRUN = 3'h5;

	typedef logic [2:0] err_code_t;
	typedef struct packed {
		logic [7:0] number;
		logic [7:0] axis;
	} svc_ctrl_t;
	typedef struct packed {
		logic [2:0] axis;
		logic [2:0] count;
		logic [3:0][2:0] codes;
	} diag_t;
	typedef struct packed {
		logic perr;
		logic [7:0] data;
	} rx_char_t;
endpackage

// ### rtl/encoder_bus_master.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// character fifo
// ----------------------------------------
module char_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	output logic [WIDTH-1:0] rd_data_o,
	output logic rd_valid_o,
	input wire logic rd_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	wire push = wr_valid_i && wr_ready_o;
	wire pop = rd_valid_o && rd_ready_i;
	assign wr_ready_o = (cnt != (AW+1)'(DEPTH));
	assign rd_valid_o = (cnt != '0);
	assign rd_data_o = mem[rp];
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end
		else
		begin
			if (push)
			begin
				mem[wp] <= wr_data_i;
				wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
			end
			if (pop)
				rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ----------------------------------------
// encoder bus master
// ----------------------------------------
module encoder_bus_master #(
	parameter int REPLY_TIMEOUT = enc_bus_pkg::REPLY_TIMEOUT_CYCLES
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic rx_data_i,
	output logic tx_addr_o,
	input wire logic poll_en_i,
	input wire logic [2:0] num_axes_i,
	input wire logic slot_long_i,
	input wire logic cam_mode_i,
	input wire logic [3:0][29:0] cam_pattern_i,
	input wire logic [3:0][4:0] node_addr_i,
	input wire logic diag_long_i,
	input wire enc_bus_pkg::svc_ctrl_t svc_i,
	input wire logic preset_pin_i,
	output logic [3:0][31:0] slot_o,
	output logic [4:0] in_byte_count_o,
	output logic [7:0] cassette_status_o,
	output logic [7:0] cycle_o,
	output enc_bus_pkg::diag_t diag_o,
	output logic diag_valid_o,
	output logic preset_load_o,
	output logic preset_sel_o
);
	import enc_bus_pkg::*;

	function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] d);
		logic [7:0] c;
		c = crc ^ d;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		return c;
	endfunction

	function automatic logic [29:0] abs_diff(input logic [29:0] a, input logic [29:0] b);
		return (a > b) ? a - b : b - a;
	endfunction

	// ----------------------------------------
	// bit clock and receiver
	// ----------------------------------------
	logic [4:0] tick_cnt;
	wire tick = (tick_cnt == TICK_LAST);
	logic rx_busy;
	logic [2:0] rx_ovs;
	logic [3:0] rx_bitn;
	logic [8:0] rx_sh;
	rx_char_t rx_char;
	logic rx_valid;
	wire rx_ready;
	wire rx_sample = tick && rx_busy && (rx_ovs == SAMPLE_PHASE);
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			tick_cnt <= '0;
			rx_busy <= 1'b0;
			rx_ovs <= '0;
			rx_bitn <= '0;
			rx_sh <= '0;
			rx_valid <= 1'b0;
			rx_char <= '0;
		end
		else
		begin
			tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
			rx_valid <= 1'b0;
			if (tick && !rx_busy && !rx_data_i)
			begin
				rx_busy <= 1'b1;
				rx_ovs <= '0;
				rx_bitn <= '0;
			end
			else if (tick && rx_busy)
				rx_ovs <= rx_ovs + 1'b1;
			if (rx_sample)
			begin
				rx_bitn <= rx_bitn + 1'b1;
				if (rx_bitn == 4'h0 && rx_data_i)
					rx_busy <= 1'b0;
				else if (rx_bitn == STOP_INDEX)
				begin
					rx_busy <= 1'b0;
					rx_valid <= 1'b1;
					rx_char.data <= rx_sh[7:0];
					rx_char.perr <= (^rx_sh) | !rx_data_i;
				end
				else if (rx_bitn != 4'h0)
					rx_sh <= {rx_data_i, rx_sh[8:1]};
			end
		end
	end

	// ----------------------------------------
	// reply buffering
	// ----------------------------------------
	rx_char_t fifo_out;
	logic fifo_valid;
	logic fifo_pop_ready;
	logic ovr_pend;
	char_fifo #(
		.WIDTH($bits(rx_char_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.wr_data_i(rx_char),
		.wr_valid_i(rx_valid),
		.wr_ready_o(rx_ready),
		.rd_data_o(fifo_out),
		.rd_valid_o(fifo_valid),
		.rd_ready_i(fifo_pop_ready)
	);

	// ----------------------------------------
	// transmitter on the address pair
	// ----------------------------------------
	logic [10:0] tx_sh;
	logic [3:0] tx_left;
	logic [2:0] tx_ovs;
	logic tx_load;
	logic [7:0] tx_byte;
	wire tx_busy = (tx_left != '0);
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			tx_sh <= '1;
			tx_left <= '0;
			tx_ovs <= '0;
			tx_addr_o <= 1'b1;
		end
		else
		begin
			tx_addr_o <= tx_sh[0];
			if (tx_load)
			begin
				tx_sh <= {1'b1, ^tx_byte, tx_byte, 1'b0};
				tx_left <= 4'hB;
				tx_ovs <= '0;
			end
			else if (tick && tx_busy)
			begin
				tx_ovs <= tx_ovs + 1'b1;
				if (tx_ovs == SHIFT_PHASE)
				begin
					tx_sh <= {1'b1, tx_sh[10:1]};
					tx_left <= tx_left - 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// polling sequence
	// ----------------------------------------
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_ADDR = 3'b001,
		M_CRC = 3'b010,
		M_WAIT = 3'b011,
		M_EVAL = 3'b100,
		M_COMMIT = 3'b101
	} mst_state_t;
	mst_state_t mst;
	logic [1:0] axis;
	logic [2:0] rx_cnt;
	logic [31:0] rx_pos;
	logic [7:0] rx_crc;
	logic rx_perr;
	logic [$clog2(REPLY_TIMEOUT+1)-1:0] tmo;
	logic [3:0][29:0] pos;
	logic [3:0] have_pos;
	logic [3:0][2:0] cons;
	logic [3:0] err_flag;
	wire [2:0] axes_n = (num_axes_i == 3'h0) ? 3'h1 : (num_axes_i > 3'h4) ? 3'h4 : num_axes_i;
	wire last_axis = ({1'b0, axis} == axes_n - 3'h1);
	wire timed_out = (tmo == '0);
	wire plaus_ok = (rx_pos[31:30] == 2'b00) && (!have_pos[axis] || abs_diff(rx_pos[29:0], pos[axis]) <= MAX_STEP);
	wire [2:0] eval_code = timed_out ? ERR_TIMEOUT :
		rx_perr ? ERR_PARITY :
		(rx_crc != '0) ? ERR_CRC :
		!plaus_ok ? ERR_PLAUS : ERR_NONE;
	assign fifo_pop_ready = (mst == M_WAIT); // stalls outside the reply window
	// loads on a tick, otherwise the start bit comes out short
	assign tx_load = ((mst == M_ADDR) || (mst == M_CRC)) && !tx_busy && tick;
	assign tx_byte = (mst == M_ADDR) ? {3'h0, node_addr_i[axis]} : crc8(CRC_INIT, {3'h0, node_addr_i[axis]});

	// ----------------------------------------
	// error stacks, index 0 is the cassette
	// ----------------------------------------
	logic [4:0][ERR_DEPTH-1:0][2:0] stk;
	logic [4:0][3:0] stk_cnt;
	logic push_en;
	logic [2:0] push_idx;
	logic [2:0] push_code;
	logic pop_en;
	logic [2:0] pop_idx;
	wire eval_push = (mst == M_EVAL) && (eval_code != ERR_NONE);
	assign push_en = eval_push || ovr_pend;
	assign push_idx = eval_push ? {1'b0, axis} + 3'h1 : CASSETTE_AXIS;
	assign push_code = eval_push ? eval_code : ERR_OVERRUN;
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			stk <= '0;
			stk_cnt <= '0;
		end
		else
		begin
			if (push_en) // newest at index 0, oldest dropped when full
			begin
				for (int i = ERR_DEPTH - 1; i > 0; i--)
					stk[push_idx][i] <= stk[push_idx][i-1];
				stk[push_idx][0] <= push_code;
				if (stk_cnt[push_idx] != 4'(ERR_DEPTH))
					stk_cnt[push_idx] <= stk_cnt[push_idx] + 1'b1;
			end
			if (pop_en)
			begin
				for (int i = 0; i < ERR_DEPTH - 1; i++)
					stk[pop_idx][i] <= stk[pop_idx][i+1];
				stk[pop_idx][ERR_DEPTH-1] <= ERR_NONE;
				stk_cnt[pop_idx] <= stk_cnt[pop_idx] - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			ovr_pend <= 1'b0;
		else if (rx_valid && !rx_ready)
			ovr_pend <= 1'b1;
		else if (!eval_push)
			ovr_pend <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			mst <= M_IDLE;
			axis <= '0;
			rx_cnt <= '0;
			rx_pos <= '0;
			rx_crc <= CRC_INIT;
			rx_perr <= 1'b0;
			tmo <= '0;
			pos <= '0;
			have_pos <= '0;
			cons <= '0;
		end
		else
		begin
			case (mst)
				M_IDLE:
				begin
					axis <= '0;
					if (poll_en_i)
						mst <= M_ADDR;
				end
				M_ADDR:
					if (tx_load)
						mst <= M_CRC;
				M_CRC:
					if (tx_load)
					begin
						mst <= M_WAIT;
						rx_cnt <= '0;
						rx_crc <= CRC_INIT;
						rx_perr <= 1'b0;
						tmo <= $bits(tmo)'(REPLY_TIMEOUT);
					end
				M_WAIT: // timeout counts down only after the request is fully out
				begin
					if (!tx_busy && !timed_out)
						tmo <= tmo - 1'b1;
					if (fifo_valid)
					begin
						rx_crc <= crc8(rx_crc, fifo_out.data);
						rx_perr <= rx_perr | fifo_out.perr;
						if (rx_cnt != REPLY_LAST)
							rx_pos <= {fifo_out.data, rx_pos[31:8]};
						rx_cnt <= rx_cnt + 1'b1;
					end
					if ((fifo_valid && rx_cnt == REPLY_LAST) || timed_out)
						mst <= M_EVAL;
				end
				M_EVAL:
				begin
					if (eval_code == ERR_NONE)
					begin
						pos[axis] <= rx_pos[29:0];
						have_pos[axis] <= 1'b1;
						cons[axis] <= '0;
					end
					else if (cons[axis] != 3'h7)
						cons[axis] <= cons[axis] + 1'b1;
					axis <= axis + 1'b1;
					mst <= last_axis ? M_COMMIT : M_ADDR;
				end
				M_COMMIT:
					mst <= M_IDLE;
				default:
					mst <= M_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// error flags and consistent slot update
	// ----------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			err_flag <= '0;
		else
			for (int a = 0; a < MAX_AXES; a++)
				if (mst == M_EVAL && axis == 2'(a) && eval_code != ERR_NONE && cons[a] >= ERR_TOLERANCE)
					err_flag[a] <= 1'b1; // set wins over the clear below
				else if (pop_en && pop_idx == 3'(a + 1) && stk_cnt[a+1] == 4'h1)
					err_flag[a] <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			slot_o <= '0;
			cycle_o <= '0;
			in_byte_count_o <= {1'b0, STATUS_BYTES};
			cassette_status_o <= '0;
		end
		else
		begin
			in_byte_count_o <= {1'b0, STATUS_BYTES} + (slot_long_i ? {axes_n, 2'b00} : {1'b0, axes_n, 1'b0});
			cassette_status_o <= {stk_cnt[0] != '0, 7'h00};
			if (mst == M_COMMIT) // all slots change in one cycle
			begin
				cycle_o <= cycle_o + 1'b1;
				for (int a = 0; a < MAX_AXES; a++)
				begin
					logic [29:0] v;
					v = cam_mode_i ? cam_pattern_i[a] : pos[a];
					if (3'(a) >= axes_n)
						slot_o[a] <= '0;
					else if (slot_long_i)
						slot_o[a] <= {err_flag[a], 1'b0, v};
					else
						slot_o[a] <= {16'h0000, err_flag[a], v[SHORT_ERR_BIT-1:0]};
				end
			end
		end
	end

	// ----------------------------------------
	// services, running beside the poll loop
	// ----------------------------------------
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_POP = 2'b01,
		S_REPORT = 2'b10
	} svc_state_t;
	svc_state_t svc;
	logic [7:0] svc_prev;
	logic [2:0] svc_axis;
	logic [2:0] svc_k;
	logic [2:0] svc_last;
	logic preset_prev;
	wire svc_go = svc_i.number[SVC_ACTIVATE_BIT] && !svc_prev[SVC_ACTIVATE_BIT];
	wire svc_axis_ok = (svc_i.axis <= 8'(MAX_AXES));
	wire pop_ok = !(push_en && push_idx == svc_axis);
	assign pop_idx = svc_axis;
	assign pop_en = (svc == S_POP) && pop_ok && (stk_cnt[svc_axis] != '0);
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			svc <= S_IDLE;
			svc_prev <= '0;
			svc_axis <= '0;
			svc_k <= '0;
			svc_last <= '0;
			diag_o <= '0;
			diag_valid_o <= 1'b0;
			preset_sel_o <= 1'b0;
			preset_prev <= 1'b0;
			preset_load_o <= 1'b0;
		end
		else
		begin
			svc_prev <= svc_i.number;
			preset_prev <= preset_pin_i;
			preset_load_o <= preset_pin_i && !preset_prev;
			diag_valid_o <= 1'b0;
			if (svc_go)
				preset_sel_o <= svc_i.number[SVC_PRESET2_BIT];
			case (svc)
				S_IDLE:
					if (svc_go && svc_i.number[SVC_POLL_BIT] && svc_axis_ok)
					begin
						svc <= S_POP;
						svc_axis <= svc_i.axis[2:0];
						svc_k <= '0;
						svc_last <= diag_long_i ? DIAG_LONG_LAST : DIAG_SHORT_LAST;
						diag_o <= '0;
					end
				S_POP:
					if (pop_ok)
					begin
						diag_o.codes[svc_k[1:0]] <= stk[svc_axis][0];
						diag_o.count <= svc_k + 3'h1;
						svc_k <= svc_k + 1'b1;
						if (svc_k == svc_last)
							svc <= S_REPORT;
					end
				S_REPORT:
				begin
					diag_o.axis <= svc_axis;
					diag_valid_o <= 1'b1;
					svc <= S_IDLE;
				end
				default:
					svc <= S_IDLE;
			endcase
		end
	end
endmodule

`default_nettype wire

// ### bench/encoder_bus_master_checker.sv
`timescale 1ns/1ps
`default_nettype none
module encoder_bus_master_checker #(
	parameter int REPLY_TIMEOUT = 10000
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic rx_data_i,
	input wire logic tx_addr_o,
	input wire logic poll_en_i,
	input wire logic [2:0] num_axes_i,
	input wire logic slot_long_i,
	input wire logic cam_mode_i,
	input wire logic [3:0][29:0] cam_pattern_i,
	input wire logic [3:0][4:0] node_addr_i,
	input wire logic diag_long_i,
	input wire enc_bus_pkg::svc_ctrl_t svc_i,
	input wire logic preset_pin_i,
	input wire logic [3:0][31:0] slot_o,
	input wire logic [4:0] in_byte_count_o,
	input wire logic [7:0] cassette_status_o,
	input wire logic [7:0] cycle_o,
	input wire enc_bus_pkg::diag_t diag_o,
	input wire logic diag_valid_o,
	input wire logic preset_load_o,
	input wire logic preset_sel_o
);
	import enc_bus_pkg::*;
	// ----------------------------------------
	// helper state
	// ----------------------------------------
	logic busy;
	logic prev_go;
	logic [2:0] svc_axis;
	logic [10:0] low_run;
	logic take;
	logic [2:0] eff_axes;
	logic [4:0] exp_bytes;
	assign take = svc_i.number[6] && !prev_go && svc_i.number[0] && svc_i.axis <= 8'h04 && !busy;
	assign eff_axes = (num_axes_i == 3'h0) ? 3'h1 : ((num_axes_i > 3'h4) ? 3'h4 : num_axes_i);
	assign exp_bytes = 5'h02 + {2'b00, eff_axes} * (slot_long_i ? 5'h04 : 5'h02);
	always_ff @(posedge clk_i)
	begin
		prev_go <= svc_i.number[6];
		busy <= (srst_i || diag_valid_o) ? 1'b0 : (busy || take);
		svc_axis <= take ? svc_i.axis[2:0] : svc_axis;
		low_run <= tx_addr_o ? 11'h0 : low_run + 11'h1;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	sequence s_commit;
		$changed(cycle_o);
	endsequence
	sequence s_short;
		##1 !diag_valid_o ##[1:11] diag_valid_o && diag_o.count == 3'h1;
	endsequence
	sequence s_long;
		##1 !diag_valid_o [*4] ##[1:11] diag_valid_o && diag_o.count == 3'h4;
	endsequence
	property p_preset_load;
		$rose(preset_pin_i) |-> ##[1:2] (preset_load_o ##1 !preset_load_o);
	endproperty
	a_preset_load: assert property (p_preset_load) else $error("preset load pulse wrong");
	property p_preset_sel;
		$rose(svc_i.number[6]) |=> preset_sel_o == $past(svc_i.number[1]);
	endproperty
	a_preset_sel: assert property (p_preset_sel) else $error("preset select not taken");
	property p_diag_short;
		take && !diag_long_i |-> s_short;
	endproperty
	a_diag_short: assert property (p_diag_short) else $error("short diag answer wrong");
	property p_diag_long;
		take && diag_long_i |-> s_long;
	endproperty
	a_diag_long: assert property (p_diag_long) else $error("long diag answer wrong");
	property p_diag_cause;
		diag_valid_o |-> busy && diag_o.axis == svc_axis;
	endproperty
	a_diag_cause: assert property (p_diag_cause) else $error("diag without request");
	property p_slot_commit;
		$changed(slot_o) |-> s_commit;
	endproperty
	a_slot_commit: assert property (p_slot_commit) else $error("slot changed outside commit");
	property p_byte_count;
		s_commit |-> in_byte_count_o == $past(exp_bytes);
	endproperty
	a_byte_count: assert property (p_byte_count) else $error("input byte count wrong");
	property p_unused;
		s_commit |-> ($past(eff_axes) < 3'h4 -> slot_o[3] == 32'h0)
			&& ($past(eff_axes) < 3'h3 -> slot_o[2] == 32'h0);
	endproperty
	a_unused: assert property (p_unused) else $error("unused slot not zero");
	property p_slot_format;
		s_commit |-> ($past(slot_long_i) ? !slot_o[0][30] : slot_o[0][31:16] == 16'h0);
	endproperty
	a_slot_format: assert property (p_slot_format) else $error("slot format wrong");
	property p_tx_bit;
		$rose(tx_addr_o) |-> low_run % 11'h0A0 == 11'h0 && low_run <= 11'h640;
	endproperty
	a_tx_bit: assert property (p_tx_bit) else $error("request bit timing wrong");
endmodule

bind encoder_bus_master encoder_bus_master_checker #(.REPLY_TIMEOUT(REPLY_TIMEOUT)) checker_inst (
	.clk_i(clk_i), .srst_i(srst_i), .rx_data_i(rx_data_i), .tx_addr_o(tx_addr_o), .poll_en_i(poll_en_i),
	.num_axes_i(num_axes_i), .slot_long_i(slot_long_i), .cam_mode_i(cam_mode_i), .cam_pattern_i(cam_pattern_i),
	.node_addr_i(node_addr_i), .diag_long_i(diag_long_i), .svc_i(svc_i), .preset_pin_i(preset_pin_i),
	.slot_o(slot_o), .in_byte_count_o(in_byte_count_o), .cassette_status_o(cassette_status_o),
	.cycle_o(cycle_o), .diag_o(diag_o), .diag_valid_o(diag_valid_o), .preset_load_o(preset_load_o),
	.preset_sel_o(preset_sel_o));
`default_nettype wire

// ### bench/enc_node_model.sv
`timescale 1ns/1ps
`default_nettype none
module enc_node_model (
	input wire logic clk_i,
	input wire logic tx_addr_i,
	input wire logic [31:0] pos_i,
	input wire logic [1:0] fault_i,
	output logic rx_data_o
);
	// ----------------------------------------
	// encoder side of the serial bus
	// ----------------------------------------
	localparam int BIT = 160;
	logic [7:0] req, rcrc, crc;
	logic b0, b1;
	logic [31:0] val;
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++)
			r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
		return r;
	endfunction
	task automatic get_char(output logic [7:0] d, output logic bad);
		while (tx_addr_i !== 1'b0)
			@(posedge clk_i);
		repeat (BIT / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT) @(posedge clk_i);
			d[i] = tx_addr_i;
		end
		repeat (BIT) @(posedge clk_i);
		bad = tx_addr_i ^ (^d);
		repeat (BIT) @(posedge clk_i);
		bad = bad | !tx_addr_i;
	endtask
	task automatic put_char(input logic [7:0] d, input logic flip);
		logic [10:0] f;
		f = {1'b1, (^d) ^ flip, d, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			rx_data_o <= f[i];
			repeat (BIT) @(posedge clk_i);
		end
	endtask
	initial
	begin
		rx_data_o = 1'b1;
		forever
		begin
			get_char(req, b0);
			get_char(rcrc, b1);
			// broadcast address 0 and damaged requests get no reply
			if (!b0 && !b1 && rcrc == crc8(8'h00, req) && req[7:5] == 3'h0 && req[4:0] != 5'h0 && fault_i != 2'h3)
			begin
				val = pos_i + {27'h0, req[4:0]};
				crc = 8'h00;
				repeat (40 + 100 * int'(req[1:0])) @(posedge clk_i);
				for (int k = 0; k < 4; k++)
				begin
					crc = crc8(crc, val[8 * k +: 8]);
					put_char(val[8 * k +: 8], fault_i == 2'h1 && k == 2);
				end
				put_char(crc ^ {7'h0, fault_i == 2'h2}, 1'b0);
			end
		end
	end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import enc_bus_pkg::*;
	// ----------------------------------------
	// stimulus and checks
	// ----------------------------------------
	localparam int TMO = 9500;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic rx, tx;
	logic poll = 1'b0;
	logic slong = 1'b1;
	logic cam_on = 1'b0;
	logic dlong = 1'b0;
	logic pin = 1'b0;
	logic [2:0] axes = 3'h2;
	logic [3:0][29:0] cam = '0;
	svc_ctrl_t svc = '0;
	logic [31:0] pos = 32'h0012_3456;
	logic [1:0] fault = 2'h0;
	logic [3:0][31:0] slot;
	logic [4:0] nbytes;
	logic [7:0] cstat;
	logic [7:0] cyc;
	diag_t diag;
	logic dval, pload, psel;
	logic [31:0] n;
	int fails = 0;
	int checked = 0;
	int seed = 32'hBF98;
	always #10 clk = ~clk;
	encoder_bus_master #(.REPLY_TIMEOUT(TMO)) dut (.clk_i(clk), .srst_i(srst), .rx_data_i(rx), .tx_addr_o(tx),
		.poll_en_i(poll), .num_axes_i(axes), .slot_long_i(slong), .cam_mode_i(cam_on), .cam_pattern_i(cam),
		.node_addr_i({5'h4, 5'h3, 5'h2, 5'h1}), .diag_long_i(dlong), .svc_i(svc), .preset_pin_i(pin),
		.slot_o(slot), .in_byte_count_o(nbytes), .cassette_status_o(cstat), .cycle_o(cyc), .diag_o(diag),
		.diag_valid_o(dval), .preset_load_o(pload), .preset_sel_o(psel));
	enc_node_model enc (.clk_i(clk), .tx_addr_i(tx), .pos_i(pos), .fault_i(fault), .rx_data_o(rx));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one pulse starts a cycle; it runs to its commit
	task automatic run_cycle();
		logic [7:0] c0;
		c0 = cyc;
		poll = 1'b1;
		@(negedge clk);
		poll = 1'b0;
		for (int i = 0; i < 60000 && cyc === c0; i++)
			@(negedge clk);
		if (cyc === c0)
		begin
			fails++;
			conclude();
		end
		chk("cycle", {24'h0, c0 + 8'h01}, {24'h0, cyc});
	endtask
	function automatic logic [31:0] exp_slot(input int k);
		logic [29:0] v;
		v = cam_on ? cam[k] : 30'(pos + 32'(k + 1));
		return slong ? {2'b00, v} : {17'h0, v[14:0]};
	endfunction
	function automatic int eff_axes();
		return (axes == 3'h0) ? 1 : (axes > 3'h4) ? 4 : int'(axes);
	endfunction
	task automatic chk_slots();
		for (int k = 0; k < 4; k++)
			chk("slot", (k < eff_axes()) ? exp_slot(k) : 32'h0, slot[k]);
		chk("bytes", 32'h2 + 32'(eff_axes()) * (slong ? 32'h4 : 32'h2), {27'h0, nbytes});
	endtask
	task automatic service(input logic [7:0] num, input logic [2:0] ax, input logic [2:0] cnt, input logic [11:0] codes);
		logic got;
		got = 1'b0;
		svc = {num, 5'h0, ax};
		for (int i = 0; i < 20; i++)
		begin
			@(negedge clk);
			if (dval === 1'b1)
			begin
				got = 1'b1;
				chk("diag", {14'h0, ax, cnt, codes}, {14'h0, diag});
			end
		end
		svc = '0;
		@(negedge clk);
		chk("preset_sel", {31'h0, num[1]}, {31'h0, psel});
		chk("served", {31'h0, num[0]}, {31'h0, got});
	endtask
	initial
	begin
		repeat (16) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		chk("preset_sel", 32'h0, {31'h0, psel});
		pin = 1'b1;
		n = 32'h0;
		repeat (4)
		begin
			@(negedge clk);
			n = n + {31'h0, pload};
		end
		chk("preset_load", 32'h1, n);
		run_cycle();
		chk_slots();
		chk("cassette_status", 32'h0, {24'h0, cstat});
		axes = 3'h1;
		fault = 2'h1;
		run_cycle();
		service(8'h41, 3'h1, 3'h1, 12'h002);
		fault = 2'h2;
		run_cycle();
		fault = 2'h3;
		run_cycle();
		fault = 2'h0;
		pos = 32'h8012_3456;
		run_cycle();
		chk("err_flag", 32'h0, {31'h0, slot[0][31]});
		dlong = 1'b1;
		service(8'h41, 3'h1, 3'h4, {3'h0, 3'h3, 3'h1, 3'h4});
		pos = 32'h0012_3456 + ($random(seed) & 32'h000F_FFFF);
		cam[0] = 30'($random(seed));
		cam[1] = 30'($random(seed));
		slong = 1'b0;
		cam_on = 1'b1;
		axes = 3'h0;
		run_cycle();
		chk_slots();
		dlong = 1'b0;
		service(8'h42, 3'h0, 3'h0, 12'h000);
		service(8'h41, 3'h0, 3'h1, 12'h000);
		conclude();
	end
endmodule
`default_nettype wire
